// >>> inc/memsel_pkg.sv
// package: register offsets, routing bit positions and reset values
package memsel_pkg;
  localparam logic [7:0] OFS_A_PIN = 8'h00;
  localparam logic [7:0] OFS_B_PIN = 8'h01;
  localparam logic [7:0] OFS_A_MODE = 8'h02;
  localparam logic [7:0] OFS_B_MODE = 8'h03;
  localparam logic [7:0] OFS_A_OUT = 8'h04;
  localparam logic [7:0] OFS_B_OUT = 8'h05;
  localparam logic [7:0] OFS_A_DIR = 8'h06;
  localparam logic [7:0] OFS_B_DIR = 8'h07;
  localparam logic [7:0] OFS_A_DRV = 8'h08;
  localparam logic [7:0] OFS_B_DRV = 8'h09;
  localparam logic [7:0] OFS_A_IMC = 8'h0a;
  localparam logic [7:0] OFS_B_IMC = 8'h0b;
  localparam logic [7:0] OFS_A_OEN = 8'h0c;
  localparam logic [7:0] OFS_B_OEN = 8'h0d;
  localparam logic [7:0] OFS_C_PIN = 8'h10;
  localparam logic [7:0] OFS_D_PIN = 8'h11;
  localparam logic [7:0] OFS_C_OUT = 8'h12;
  localparam logic [7:0] OFS_D_OUT = 8'h13;
  localparam logic [7:0] OFS_C_DIR = 8'h14;
  localparam logic [7:0] OFS_D_DIR = 8'h15;
  localparam logic [7:0] OFS_C_DRV = 8'h16;
  localparam logic [7:0] OFS_D_DRV = 8'h17;
  localparam logic [7:0] OFS_C_IMC = 8'h18;
  localparam logic [7:0] OFS_C_OEN = 8'h1a;
  localparam logic [7:0] OFS_D_OEN = 8'h1b;
  localparam logic [7:0] OFS_CELL1 = 8'h20;
  localparam logic [7:0] OFS_CELL2 = 8'h21;
  localparam logic [7:0] OFS_CELL1_MASK = 8'h22;
  localparam logic [7:0] OFS_CELL2_MASK = 8'h23;
  localparam logic [7:0] OFS_PWR0 = 8'hb0;
  localparam logic [7:0] OFS_PWR2 = 8'hb4;
  localparam logic [7:0] OFS_MAIN_PROT = 8'hc0;
  localparam logic [7:0] OFS_SEC_PROT = 8'hc2;
  localparam logic [7:0] OFS_PWR3 = 8'hc7;
  localparam logic [7:0] OFS_PAGE = 8'he0;
  localparam logic [7:0] OFS_ROUTING = 8'he2;
  // routing register bit positions
  localparam int RT_SRAM_FETCH = 0;
  localparam int RT_SEC_FETCH = 1;
  localparam int RT_MAIN_FETCH = 2;
  localparam int RT_SEC_DATA = 3;
  localparam int RT_MAIN_DATA = 4;
  localparam int RT_PORT_A_PERIPHERAL_IO_ENABLE = 7;
  localparam logic [7:0] RT_WRITABLE = 8'h9f;
  localparam logic [7:0] RT_NV_FIELD = 8'h1f;
  localparam int PWR3_STICKY_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  // memory target of one bus cycle
  typedef enum logic [4:0] {
    TGT_NONE = 5'b00001,
    TGT_MAIN = 5'b00010,
    TGT_SEC = 5'b00100,
    TGT_LOW = 5'b01000,
    TGT_CTRL = 5'b10000
  } target_e;
endpackage

// >>> hw/memsel.sv
// memory select priority, space routing and runtime control registers
// Function
// - secondary flash beats main flash on overlap
// - sram, control block, peripheral beat flash
// - only highest priority memory answers access
// - bit 4 gates data strobes to main
// - bit 3 gates data strobes to secondary
// - bit 2 gates fetch strobe to main
// - bit 1 gates fetch strobe to secondary
// - bit 0 adds fetch to sram; data always
// - reset loads routing bits 0-4 from config
// - runtime routing write overrides until reset
// - bit 7 enables port a peripheral mode
// - control block data strobes only, never fetch
// - pin level registers read pins, ignore writes
// - port a/b mode bits readable, select address-out
// - output register drives only non-cell output pins
// - direction bit one means output, readable
// - mask bit one blocks output cell access
// - power three bit one cleared only by reset
// - routing rewritable at runtime for reprogramming
module memsel
  import memsel_pkg::*;
#(
  parameter logic [7:0] NV_ROUTING = 8'h0c,
  parameter logic [7:0] NV_MAIN_PROT = 8'h00,
  parameter logic [7:0] NV_SEC_PROT = 8'h00
) (
  input wire logic mclk,
  input wire logic rst_b,
  // decoded range matches from the select equations, same clock
  input wire logic [7:0] main_flash_sector_select,
  input wire logic [3:0] secondary_flash_sector_select,
  input wire logic sram_range_select,
  input wire logic ctrl_block_select,
  input wire logic peripheral_range_select,
  // core strobes, active high here, same clock
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic program_fetch_strobe,
  input wire logic [7:0] reg_offset,
  input wire logic [7:0] wr_data,
  // register read data
  output logic [7:0] rd_data,
  // memory enables of the current cycle
  output logic [7:0] main_flash_enable,
  output logic [3:0] secondary_flash_enable,
  output logic sram_enable,
  output logic ctrl_block_enable,
  output logic peripheral_enable,
  output logic port_a_peripheral_io_enable,
  output logic [7:0] memory_page,
  // port pins, asynchronous
  input wire logic [7:0] pin_a,
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  output logic [7:0] pin_a_out,
  output logic [7:0] pin_b_out,
  output logic [7:0] pin_c_out,
  output logic [7:0] pin_d_out,
  output logic [7:0] pin_a_oe,
  output logic [7:0] pin_b_oe,
  output logic [7:0] pin_c_oe,
  output logic [7:0] pin_d_oe,
  output logic [7:0] port_a_addr_out_mode,
  output logic [7:0] port_b_addr_out_mode,
  output logic [7:0] port_a_drive_type,
  output logic [7:0] port_b_drive_type,
  output logic [7:0] port_c_drive_type,
  output logic [7:0] port_d_drive_type,
  // pins owned by output logic cells, same clock
  input wire logic [7:0] cell_owns_a,
  input wire logic [7:0] cell_owns_b,
  input wire logic [7:0] cell_owns_c,
  input wire logic [7:0] cell_owns_d,
  input wire logic [7:0] input_logic_cell_a,
  input wire logic [7:0] input_logic_cell_b,
  input wire logic [7:0] input_logic_cell_c,
  input wire logic [7:0] output_logic_cell_one,
  input wire logic [7:0] output_logic_cell_two,
  output logic [7:0] cell_one_load,
  output logic [7:0] cell_two_load,
  output logic [7:0] cell_load_data,
  output logic [7:0] power_control_zero,
  output logic [7:0] power_control_two,
  output logic [7:0] power_control_three,
  // hardware set of the sticky power bit, same clock
  input wire logic pwr3_bit1_set
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] routing;
    logic nv_pending;
    logic [7:0] mode_a;
    logic [7:0] mode_b;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic [7:0] out_c;
    logic [7:0] out_d;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] dir_d;
    logic [7:0] drv_a;
    logic [7:0] drv_b;
    logic [7:0] drv_c;
    logic [7:0] drv_d;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] pwr0;
    logic [7:0] pwr2;
    logic [7:0] pwr3;
    logic [7:0] page;
    logic [7:0] rdata;
    logic [7:0] ld1;
    logic [7:0] ld2;
    logic [7:0] ldat;
    logic [31:0] pin_s1;
    logic [31:0] pin_s2;
  } state_s;

  state_s st_r, st_nxt;
  target_e tgt;
  logic data_cyc, fetch_cyc, wr_hit, rd_hit;
  logic [7:0] rd_mux;

  // ==========================================================
  // priority and routing
  always_comb begin
    data_cyc = rd_strobe | wr_strobe;
    fetch_cyc = program_fetch_strobe;
    main_flash_enable = '0;
    secondary_flash_enable = '0;
    sram_enable = 1'b0;
    ctrl_block_enable = 1'b0;
    peripheral_enable = 1'b0;
    // top level first: the lower levels are simply hidden
    if (sram_range_select | ctrl_block_select | peripheral_range_select)
      tgt = TGT_LOW;
    else if (|secondary_flash_sector_select)
      tgt = TGT_SEC;
    else if (|main_flash_sector_select)
      tgt = TGT_MAIN;
    else
      tgt = TGT_NONE;
    unique case (tgt)
      TGT_LOW: begin
        // sram always in data space, fetch only by bit 0
        sram_enable = sram_range_select &
          (data_cyc | (fetch_cyc & st_r.routing[RT_SRAM_FETCH]));
        ctrl_block_enable = ctrl_block_select & data_cyc;
        peripheral_enable = peripheral_range_select &
          st_r.routing[RT_PORT_A_PERIPHERAL_IO_ENABLE] & (data_cyc | fetch_cyc);
      end
      TGT_SEC: begin
        if ((data_cyc & st_r.routing[RT_SEC_DATA]) |
            (fetch_cyc & st_r.routing[RT_SEC_FETCH]))
          secondary_flash_enable = secondary_flash_sector_select;
      end
      TGT_MAIN: begin
        if ((data_cyc & st_r.routing[RT_MAIN_DATA]) |
            (fetch_cyc & st_r.routing[RT_MAIN_FETCH]))
          main_flash_enable = main_flash_sector_select;
      end
      TGT_NONE: begin
      end
    endcase
  end

  assign wr_hit = ctrl_block_enable & wr_strobe;
  assign rd_hit = ctrl_block_enable & rd_strobe;

  // ==========================================================
  // register read mux; unused locations read zero
  always_comb begin
    unique case (reg_offset)
      OFS_A_PIN: rd_mux = st_r.pin_s2[7:0];
      OFS_B_PIN: rd_mux = st_r.pin_s2[15:8];
      OFS_C_PIN: rd_mux = st_r.pin_s2[23:16];
      OFS_D_PIN: rd_mux = st_r.pin_s2[31:24];
      OFS_A_MODE: rd_mux = st_r.mode_a;
      OFS_B_MODE: rd_mux = st_r.mode_b;
      OFS_A_OUT: rd_mux = st_r.out_a;
      OFS_B_OUT: rd_mux = st_r.out_b;
      OFS_C_OUT: rd_mux = st_r.out_c;
      OFS_D_OUT: rd_mux = st_r.out_d;
      OFS_A_DIR: rd_mux = st_r.dir_a;
      OFS_B_DIR: rd_mux = st_r.dir_b;
      OFS_C_DIR: rd_mux = st_r.dir_c;
      OFS_D_DIR: rd_mux = st_r.dir_d;
      OFS_A_DRV: rd_mux = st_r.drv_a;
      OFS_B_DRV: rd_mux = st_r.drv_b;
      OFS_C_DRV: rd_mux = st_r.drv_c;
      OFS_D_DRV: rd_mux = st_r.drv_d;
      OFS_A_IMC: rd_mux = input_logic_cell_a;
      OFS_B_IMC: rd_mux = input_logic_cell_b;
      OFS_C_IMC: rd_mux = input_logic_cell_c;
      OFS_A_OEN: rd_mux = pin_a_oe;
      OFS_B_OEN: rd_mux = pin_b_oe;
      OFS_C_OEN: rd_mux = pin_c_oe;
      OFS_D_OEN: rd_mux = pin_d_oe;
      // masked cells read as zero
      OFS_CELL1: rd_mux = output_logic_cell_one & ~st_r.mask1;
      OFS_CELL2: rd_mux = output_logic_cell_two & ~st_r.mask2;
      OFS_CELL1_MASK: rd_mux = st_r.mask1;
      OFS_CELL2_MASK: rd_mux = st_r.mask2;
      OFS_PWR0: rd_mux = st_r.pwr0;
      OFS_PWR2: rd_mux = st_r.pwr2;
      OFS_PWR3: rd_mux = st_r.pwr3;
      OFS_MAIN_PROT: rd_mux = NV_MAIN_PROT;
      OFS_SEC_PROT: rd_mux = NV_SEC_PROT;
      OFS_PAGE: rd_mux = st_r.page;
      OFS_ROUTING: rd_mux = st_r.routing;
      default: rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_s1 = {pin_d, pin_c, pin_b, pin_a};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.ld1 = 8'h00;
    st_nxt.ld2 = 8'h00;
    st_nxt.rdata = rd_hit ? rd_mux : st_r.rdata;
    // first clock after reset picks up the configured routing
    if (st_r.nv_pending) begin
      st_nxt.routing = {1'b0, 2'b00, NV_ROUTING[4:0]};
      st_nxt.nv_pending = 1'b0;
    end
    if (wr_hit) begin
      unique case (reg_offset)
        OFS_A_MODE: st_nxt.mode_a = wr_data;
        OFS_B_MODE: st_nxt.mode_b = wr_data;
        OFS_A_OUT: st_nxt.out_a = wr_data;
        OFS_B_OUT: st_nxt.out_b = wr_data;
        OFS_C_OUT: st_nxt.out_c = wr_data;
        OFS_D_OUT: st_nxt.out_d = wr_data;
        OFS_A_DIR: st_nxt.dir_a = wr_data;
        OFS_B_DIR: st_nxt.dir_b = wr_data;
        OFS_C_DIR: st_nxt.dir_c = wr_data;
        OFS_D_DIR: st_nxt.dir_d = wr_data;
        OFS_A_DRV: st_nxt.drv_a = wr_data;
        OFS_B_DRV: st_nxt.drv_b = wr_data;
        OFS_C_DRV: st_nxt.drv_c = wr_data;
        OFS_D_DRV: st_nxt.drv_d = wr_data;
        OFS_CELL1: st_nxt.ld1 = ~st_r.mask1;
        OFS_CELL2: st_nxt.ld2 = ~st_r.mask2;
        OFS_CELL1_MASK: st_nxt.mask1 = wr_data;
        OFS_CELL2_MASK: st_nxt.mask2 = wr_data;
        OFS_PWR0: st_nxt.pwr0 = wr_data;
        OFS_PWR2: st_nxt.pwr2 = wr_data;
        // software can set the sticky bit but never clear it
        OFS_PWR3: st_nxt.pwr3 = wr_data |
          (st_r.pwr3 & (8'h01 << PWR3_STICKY_BIT));
        OFS_PAGE: st_nxt.page = wr_data;
        // live override of the reset routing
        OFS_ROUTING: begin
          st_nxt.routing = wr_data & RT_WRITABLE;
          st_nxt.nv_pending = 1'b0;
        end
        default: begin
        end
      endcase
      st_nxt.ldat = wr_data;
    end
    if (pwr3_bit1_set)
      st_nxt.pwr3[PWR3_STICKY_BIT] = 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0; // bit 7 clears with it
      st_r.nv_pending <= 1'b1;
      st_r.routing <= {3'b000, NV_ROUTING[4:0]};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rd_data = st_r.rdata;
  assign port_a_peripheral_io_enable = st_r.routing[RT_PORT_A_PERIPHERAL_IO_ENABLE];
  assign memory_page = st_r.page;
  assign port_a_addr_out_mode = st_r.mode_a;
  assign port_b_addr_out_mode = st_r.mode_b;
  assign port_a_drive_type = st_r.drv_a;
  assign port_b_drive_type = st_r.drv_b;
  assign port_c_drive_type = st_r.drv_c;
  assign port_d_drive_type = st_r.drv_d;
  // ==========================================================
  // pin drive per port
  port_drive #(
    .W(8)
  ) u_drive_a (
    .out_lvl(st_r.out_a),
    .dir(st_r.dir_a),
    .addr_mode(st_r.mode_a),
    .cell_owns(cell_owns_a),
    .pin_out(pin_a_out),
    .pin_oe(pin_a_oe)
  );
  port_drive #(
    .W(8)
  ) u_drive_b (
    .out_lvl(st_r.out_b),
    .dir(st_r.dir_b),
    .addr_mode(st_r.mode_b),
    .cell_owns(cell_owns_b),
    .pin_out(pin_b_out),
    .pin_oe(pin_b_oe)
  );
  port_drive #(
    .W(8)
  ) u_drive_c (
    .out_lvl(st_r.out_c),
    .dir(st_r.dir_c),
    .addr_mode(8'h00),
    .cell_owns(cell_owns_c),
    .pin_out(pin_c_out),
    .pin_oe(pin_c_oe)
  );
  port_drive #(
    .W(8)
  ) u_drive_d (
    .out_lvl(st_r.out_d),
    .dir(st_r.dir_d),
    .addr_mode(8'h00),
    .cell_owns(cell_owns_d),
    .pin_out(pin_d_out),
    .pin_oe(pin_d_oe)
  );
  assign cell_one_load = st_r.ld1;
  assign cell_two_load = st_r.ld2;
  assign cell_load_data = st_r.ldat;
  assign power_control_zero = st_r.pwr0;
  assign power_control_two = st_r.pwr2;
  assign power_control_three = st_r.pwr3;

endmodule

// ==========================================================
// pin drive of one port: out level and direction, minus cell-owned pins
module port_drive
  import memsel_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic [W-1:0] out_lvl,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] addr_mode,
  input wire logic [W-1:0] cell_owns,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe
);
  // cell-owned pins are driven elsewhere; out register stays off them
  assign pin_out = out_lvl & ~cell_owns;
  // address-out mode hands the pin to the bus, so no port drive there
  assign pin_oe = dir & ~cell_owns & ~addr_mode;
endmodule

// >>> bench/memsel_sva.sv
// assertion checker for the memory select block
module memsel_sva (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sram_range_select,
  input wire logic ctrl_block_select,
  input wire logic peripheral_range_select,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic program_fetch_strobe,
  input wire logic [7:0] reg_offset,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] main_flash_enable,
  input wire logic [3:0] secondary_flash_enable,
  input wire logic sram_enable,
  input wire logic ctrl_block_enable,
  input wire logic port_a_peripheral_io_enable,
  input wire logic [7:0] cell_one_load,
  input wire logic [7:0] power_control_three
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // priority, routing and register properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence route_write;
    ctrl_block_enable && wr_strobe && reg_offset == 8'he2;
  endsequence
  sequence route_read;
    ctrl_block_enable && rd_strobe && !wr_strobe && reg_offset == 8'he2;
  endsequence
  a_sec_hides_main: assert property (
    |secondary_flash_enable |-> main_flash_enable == 8'h00)
    else $error("main flash enabled under secondary flash");
  a_low_hides_flash: assert property (
    sram_range_select || ctrl_block_select || peripheral_range_select
    |-> main_flash_enable == 8'h00 && secondary_flash_enable == 4'h0)
    else $error("flash enabled under a low level select");
  a_fetch_no_ctrl: assert property (
    program_fetch_strobe && !rd_strobe && !wr_strobe |-> !ctrl_block_enable)
    else $error("fetch reached the control block");
  a_sram_data_path: assert property (
    sram_range_select && (rd_strobe || wr_strobe) |-> sram_enable)
    else $error("data strobe did not reach sram");
  a_route_readback: assert property (
    route_write ##1 !wr_strobe ##1 route_read
    |=> rd_data == ($past(wr_data, 3) & 8'h9f))
    else $error("routing readback differs from write");
  a_pio_follows: assert property (
    route_write |=> port_a_peripheral_io_enable == $past(wr_data[7]))
    else $error("peripheral mode bit did not follow write");
  a_reset_pio_low: assert property (
    $rose(rst_b) |-> !port_a_peripheral_io_enable)
    else $error("peripheral mode set after reset");
  a_sticky_power: assert property (
    power_control_three[1] |=> power_control_three[1])
    else $error("sticky power bit cleared without reset");
  a_load_needs_write: assert property (
    |cell_one_load |-> $past(ctrl_block_enable && wr_strobe
    && reg_offset == 8'h20))
    else $error("cell load without a write");
  a_read_holds: assert property (
    !(ctrl_block_enable && rd_strobe) |=> $stable(rd_data))
    else $error("read data changed without a read");
endmodule

bind memsel memsel_sva u_sva (.mclk, .rst_b, .sram_range_select,
  .ctrl_block_select, .peripheral_range_select, .rd_strobe, .wr_strobe,
  .program_fetch_strobe, .reg_offset, .wr_data, .rd_data,
  .main_flash_enable, .secondary_flash_enable, .sram_enable,
  .ctrl_block_enable, .port_a_peripheral_io_enable, .cell_one_load,
  .power_control_three);

// >>> bench/core_bus_model.sv
// core bus model: decoded selects, strobes and register cycles
module core_bus_model (
  input wire logic mclk,
  output logic [7:0] main_flash_sector_select,
  output logic [3:0] secondary_flash_sector_select,
  output logic sram_range_select,
  output logic ctrl_block_select,
  output logic peripheral_range_select,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic program_fetch_strobe,
  output logic [7:0] reg_offset,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // bus cycles
  initial begin
    {main_flash_sector_select, secondary_flash_sector_select} = '0;
    {sram_range_select, ctrl_block_select, peripheral_range_select} = '0;
    {rd_strobe, wr_strobe, program_fetch_strobe} = '0;
    {reg_offset, wr_data} = '0;
  end
  // callers keep one sector per array and one low select at a time
  task automatic acc(input logic [7:0] m, input logic [3:0] s,
      input logic [2:0] low, input logic [2:0] stb);
    @(posedge mclk);
    main_flash_sector_select <= m;
    secondary_flash_sector_select <= s;
    {sram_range_select, ctrl_block_select,
      peripheral_range_select} <= low;
    {rd_strobe, wr_strobe, program_fetch_strobe} <= stb;
    #1;
  endtask
  task automatic reg_cyc(input logic wr, input logic [7:0] off,
      input logic [7:0] d);
    @(posedge mclk);
    ctrl_block_select <= 1'b1;
    rd_strobe <= !wr;
    wr_strobe <= wr;
    reg_offset <= off;
    wr_data <= d;
    @(posedge mclk);
    ctrl_block_select <= 1'b0;
    rd_strobe <= 1'b0;
    wr_strobe <= 1'b0;
    // released data line must not keep showing the last byte
    wr_data <= ~d;
    #1;
  endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the memory select block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import memsel_pkg::*;
  localparam logic [7:0] NV = 8'hf5;
  logic mclk = 1'b0;
  logic rst_b, sram_range_select, ctrl_block_select, peripheral_range_select;
  logic rd_strobe, wr_strobe, program_fetch_strobe, sram_enable;
  logic ctrl_block_enable, peripheral_enable, port_a_peripheral_io_enable;
  logic pwr3_bit1_set;
  logic [3:0] secondary_flash_sector_select, secondary_flash_enable, s;
  logic [7:0] main_flash_sector_select, reg_offset, wr_data, rd_data;
  logic [7:0] main_flash_enable, pin_a_out, pin_a_oe, cell_one_load;
  logic [7:0] cell_load_data, power_control_three, pin_a, pin_b, pin_c;
  logic [7:0] pin_d, cell_owns_a, cell_owns_b, cell_owns_c, cell_owns_d;
  logic [7:0] input_logic_cell_a, input_logic_cell_b, input_logic_cell_c;
  logic [7:0] output_logic_cell_one, output_logic_cell_two, v, r, k, m;
  logic [7:0] memory_page, pin_d_out, pin_d_oe, port_a_addr_out_mode;
  logic [7:0] port_a_drive_type, cell_two_load, power_control_zero;
  logic [7:0] power_control_two;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int checks = 0;
  integer seed = 32'h1b3a;
  always #5 mclk = ~mclk;
  core_bus_model u_core (.mclk, .main_flash_sector_select,
    .secondary_flash_sector_select, .sram_range_select, .ctrl_block_select,
    .peripheral_range_select, .rd_strobe, .wr_strobe, .program_fetch_strobe,
    .reg_offset, .wr_data);
  memsel #(.NV_ROUTING(NV)) u_memsel (.mclk, .rst_b,
    .main_flash_sector_select, .secondary_flash_sector_select,
    .sram_range_select, .ctrl_block_select, .peripheral_range_select,
    .rd_strobe, .wr_strobe, .program_fetch_strobe, .reg_offset, .wr_data,
    .rd_data, .main_flash_enable, .secondary_flash_enable, .sram_enable,
    .ctrl_block_enable, .peripheral_enable, .port_a_peripheral_io_enable,
    .memory_page, .pin_a, .pin_b, .pin_c, .pin_d, .pin_a_out,
    .pin_b_out(), .pin_c_out(), .pin_d_out, .pin_a_oe, .pin_b_oe(),
    .pin_c_oe(), .pin_d_oe, .port_a_addr_out_mode,
    .port_b_addr_out_mode(), .port_a_drive_type, .port_b_drive_type(),
    .port_c_drive_type(), .port_d_drive_type(), .cell_owns_a, .cell_owns_b,
    .cell_owns_c, .cell_owns_d, .input_logic_cell_a, .input_logic_cell_b,
    .input_logic_cell_c, .output_logic_cell_one, .output_logic_cell_two,
    .cell_one_load, .cell_two_load, .cell_load_data,
    .power_control_zero, .power_control_two, .power_control_three,
    .pwr3_bit1_set);
  // ==========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    exp_q.push_back(e);
    u_core.reg_cyc(1'b0, off, ~e);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    u_core.reg_cyc(1'b1, off, d);
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  // read data lands just after the same edge that takes the read
  always @(posedge mclk) begin
    if (rst_b && ctrl_block_enable && rd_strobe) begin
      #1;
      check(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  // ==========================================================
  // scenarios
  initial begin
    rst_b = 1'b0;
    pwr3_bit1_set = 1'b0;
    {pin_a, pin_b, pin_c, pin_d} = $random(seed);
    {cell_owns_a, cell_owns_b, cell_owns_c, cell_owns_d} = $random(seed);
    {input_logic_cell_a, input_logic_cell_b, input_logic_cell_c,
      output_logic_cell_one} = $random(seed);
    output_logic_cell_two = 8'h5a;
    do_reset();
    rd(OFS_ROUTING, NV & 8'h1f);
    rd(8'h30, 8'h00);
    rd(OFS_PWR3, REG_RESET);
    $display("reset defaults done");
    for (int i = 0; i < 32; i++) begin
      v = 8'(i);
      m = 8'h01 << ($random(seed) & 7);
      s = 4'h1 << ($random(seed) & 3);
      wr(OFS_ROUTING, v | 8'h60);
      rd(OFS_ROUTING, v);
      u_core.acc(m, 4'h0, 3'b000, 3'b001);
      check(main_flash_enable, {8{v[2]}} & m);
      u_core.acc(m, 4'h0, 3'b000, 3'b100);
      check(main_flash_enable, {8{v[4]}} & m);
      u_core.acc(8'h00, s, 3'b000, 3'b001);
      check(secondary_flash_enable, {4{v[1]}} & s);
      u_core.acc(8'h00, s, 3'b000, 3'b010);
      check(secondary_flash_enable, {4{v[3]}} & s);
      u_core.acc(8'h00, 4'h0, 3'b100, 3'b001);
      check(sram_enable, v[0]);
      u_core.acc(8'h00, 4'h0, 3'b000, 3'b000);
    end
    $display("routing table done");
    wr(OFS_ROUTING, 8'h9f);
    check(port_a_peripheral_io_enable, 1'b1);
    u_core.acc(8'h01, 4'h1, 3'b000, 3'b100);
    check({main_flash_enable, secondary_flash_enable}, 12'h001);
    u_core.acc(8'h02, 4'h0, 3'b100, 3'b001);
    check({main_flash_enable, sram_enable}, 9'h001);
    u_core.acc(8'h04, 4'h2, 3'b001, 3'b100);
    check({main_flash_enable, secondary_flash_enable,
      peripheral_enable}, 13'h0001);
    u_core.acc(8'h08, 4'h0, 3'b010, 3'b001);
    check({main_flash_enable, ctrl_block_enable}, 9'h000);
    u_core.acc(8'h00, 4'h0, 3'b000, 3'b000);
    wr(OFS_ROUTING, 8'h1f);
    check(port_a_peripheral_io_enable, 1'b0);
    $display("priority done");
    r = 8'($random(seed));
    wr(OFS_A_PIN, ~pin_a);
    rd(OFS_A_PIN, pin_a);
    wr(OFS_A_DIR, 8'hff);
    wr(OFS_A_MODE, 8'h0f);
    wr(OFS_A_OUT, r);
    rd(OFS_A_MODE, 8'h0f);
    rd(OFS_A_DIR, 8'hff);
    check(pin_a_out, r & ~cell_owns_a);
    check(pin_a_oe, 8'hf0 & ~cell_owns_a);
    $display("port registers done");
    k = 8'($random(seed));
    wr(OFS_CELL1_MASK, k);
    wr(OFS_CELL1, r);
    check(cell_one_load, 8'(~k));
    check(cell_load_data, r);
    rd(OFS_CELL1, output_logic_cell_one & ~k);
    $display("cell mask done");
    wr(OFS_CELL2_MASK, 8'h00);
    wr(OFS_CELL2, k);
    check(cell_two_load, 8'hff);
    rd(OFS_CELL2, output_logic_cell_two);
    wr(OFS_PAGE, r);
    wr(OFS_PWR0, k);
    wr(OFS_PWR2, ~k);
    wr(OFS_A_DRV, ~r);
    wr(OFS_D_DIR, 8'hff);
    wr(OFS_D_OUT, k);
    rd(OFS_PAGE, r);
    check(memory_page, r);
    check(power_control_zero, k);
    check(power_control_two, 8'(~k));
    check(port_a_drive_type, 8'(~r));
    check(port_a_addr_out_mode, 8'h0f);
    check(pin_d_out, k & ~cell_owns_d);
    check(pin_d_oe, 8'(~cell_owns_d));
    $display("other registers done");
    @(posedge mclk) pwr3_bit1_set <= 1'b1;
    @(posedge mclk) pwr3_bit1_set <= 1'b0;
    wr(OFS_PWR3, 8'h01);
    rd(OFS_PWR3, 8'h03);
    wr(OFS_ROUTING, 8'h10);
    do_reset();
    rd(OFS_ROUTING, NV & 8'h1f);
    rd(OFS_PWR3, 8'h00);
    $display("sticky bit and second reset done");
    close_out();
  end
endmodule
